// ### design/cie_cfg.svh
/*
  Constants of the core interrupt enable and flag block: register
  offsets, field positions, reset values and bus encodings.
  Assumes inclusion by bare name from every design file that needs it.
*/
`ifndef CIE_CFG_SVH
`define CIE_CFG_SVH

// ============================================================
// Register byte offsets
`define CIE_OFS_CONTROL      8'h00
`define CIE_OFS_PERIPH_EN    8'h04
`define CIE_OFS_EDGE_SELECT  8'h08
`define CIE_OFS_STATUS       8'h0c
`define CIE_OFS_PERIPH_FLAGS 8'h10
`define CIE_OFS_PIN_FLAGS    8'h14

// ============================================================
// Control register fields
`define CIE_BIT_GIE          7
`define CIE_BIT_PERIPH_GROUP_ENABLE         6
`define CIE_BIT_T0IE         5
`define CIE_BIT_EXTIE        4
`define CIE_BIT_PCIE         3
`define CIE_BIT_T0F          2
`define CIE_BIT_EXTF         1
`define CIE_BIT_PCF          0

// ============================================================
// Peripheral enable fields
`define CIE_BIT_T1GATE       7
`define CIE_BIT_ADC          6
`define CIE_BIT_SRX          5
`define CIE_BIT_STX          4
`define CIE_BIT_SSP          3
`define CIE_BIT_CCP1         2
`define CIE_BIT_T2MATCH      1
`define CIE_BIT_T1OVF        0

// ============================================================
// Status register fields
`define CIE_BIT_ST_REQ       0
`define CIE_BIT_ST_PREQ      1
`define CIE_BIT_ST_CORE      2

// ============================================================
// Reset values
`define CIE_RST_CONTROL      8'h00
`define CIE_RST_PERIPH_EN    8'h00
`define CIE_RST_EDGE_SELECT  1'b0

// ============================================================
// Interrupt vector and bus encodings
`define CIE_IRQ_VECTOR       16'h0004
`define CIE_HTRANS_NONSEQ    2'b10
`define CIE_HSIZE_WORD       3'b010
`define CIE_HRESP_OKAY       1'b0

`endif

// ### design/cie_pkg.sv
/*
  Types of the core interrupt enable and flag block.
  Assumes the constants header is compiled alongside.
*/
package cie_pkg;

  // ============================================================
  // Bus data phase tracking
  typedef enum logic [0:0] {
    CIE_PH_IDLE = 1'b0,
    CIE_PH_DATA = 1'b1
  } cie_phase_t;

  // ============================================================
  // Whole state of the controller
  typedef struct packed {
    cie_phase_t  phase;
    logic        wr;
    logic [7:0]  addr;
    logic [7:0]  control;
    logic [7:0]  periph_en;
    logic        edge_select;
    logic [31:0] rdata;
    logic        irq;
    logic [15:0] vector;
  } cie_state_t;

  // ============================================================
  // Whole state of the edge detector
  typedef struct packed {
    logic        prev;
    logic        primed;
    logic        hit;
  } cie_edge_state_t;

endpackage

// ### design/cie_edge_det.sv
/*
  Edge detector for the external interrupt pin, with a selectable edge.
  Assumes the pin is already synchronous to clk_sys.
*/
`timescale 1ns/1ps
`include "cie_cfg.svh"

module cie_edge_det (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic reset,
  // Pin and edge choice
  input  wire logic pin,
  input  wire logic rising_sel,
  // One-cycle event
  output logic      edge_hit
);

  cie_pkg::cie_edge_state_t st;
  cie_pkg::cie_edge_state_t next_st;

  // ============================================================
  // Edge compare
  // The first sample after reset only primes the history, so a pin that
  // is already high at release does not look like a rising edge.
  always_comb begin
    next_st        = st;
    next_st.prev   = pin;
    next_st.primed = 1'b1;
    if (rising_sel) begin
      next_st.hit = st.primed & pin & ~st.prev;
    end else begin
      next_st.hit = st.primed & ~pin & st.prev;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign edge_hit = st.hit;

endmodule

// ### design/cie_ctrl.sv
/*
  Interrupt enable and flag logic of a small core, with an AHB-Lite
  register slave. Holds the control and peripheral enable registers,
  sets core-source flags and combines everything into one request.
  Assumes synchronous sources, one bus master and a core that pulses
  irq_taken once when it vectors.
*/
`timescale 1ns/1ps
`include "cie_cfg.svh"

module cie_ctrl #(
  parameter int PERIPH_COUNT = 8,
  parameter int PIN_COUNT    = 6
) (
  // Clock and reset
  input  wire logic                    clk_sys,
  input  wire logic                    reset,
  // AHB-Lite slave
  input  wire logic                    hsel,
  input  wire logic [31:0]             haddr,
  input  wire logic [1:0]              htrans,
  input  wire logic                    hwrite,
  input  wire logic [2:0]              hsize,
  input  wire logic [31:0]             hwdata,
  input  wire logic                    hready,
  output logic                         hreadyout,
  output logic                         hresp,
  output logic [31:0]                  hrdata,
  // Core interrupt sources
  input  wire logic                    timer0_ovf_pulse,
  input  wire logic                    ext_pin,
  input  wire logic [PIN_COUNT-1:0]    per_pin_change_flags,
  // Peripheral interrupt flags
  input  wire logic [PERIPH_COUNT-1:0] periph_flags,
  // Processor core side
  input  wire logic                    irq_taken,
  output logic                         irq_request,
  output logic [15:0]                  irq_vector
);

  cie_pkg::cie_state_t st;
  cie_pkg::cie_state_t next_st;

  logic ext_edge;
  logic addr_take;
  logic word_ok;
  logic wr_fire;
  logic [7:0] wbyte;
  logic pin_change_any;
  logic core_pending;
  logic periph_pending;
  logic request_now;

  // ============================================================
  // External pin edge
  cie_edge_det u_edge (
    .clk_sys    (clk_sys),
    .reset      (reset),
    .pin        (ext_pin),
    .rising_sel (st.edge_select),
    .edge_hit   (ext_edge)
  );

  // ============================================================
  // Bus decode
  // The slave never inserts wait states, so every transfer takes one
  // address cycle and one data cycle.
  assign addr_take = hsel & hready & htrans[1];
  assign word_ok   = (hsize == `CIE_HSIZE_WORD) & (haddr[1:0] == 2'b00);
  assign wr_fire   = (st.phase == cie_pkg::CIE_PH_DATA) & st.wr;
  assign wbyte     = hwdata[7:0];

  // ============================================================
  // Source summaries
  // The pin-change summary follows the per-pin flags directly, so it
  // cannot be cleared by a register write, only by clearing the pins.
  assign pin_change_any = |per_pin_change_flags;

  always_comb begin
    core_pending =
      (st.control[`CIE_BIT_T0IE] & st.control[`CIE_BIT_T0F]) |
      (st.control[`CIE_BIT_EXTIE] & st.control[`CIE_BIT_EXTF]) |
      (st.control[`CIE_BIT_PCIE] & st.control[`CIE_BIT_PCF]);
    periph_pending = st.control[`CIE_BIT_PERIPH_GROUP_ENABLE] &
      (|(st.periph_en & periph_flags[7:0]));
    request_now = st.control[`CIE_BIT_GIE] &
      (core_pending | periph_pending);
  end

  // ============================================================
  // Next state
  always_comb begin
    next_st = st;

    // Bus address phase capture.
    if (addr_take) begin
      next_st.phase = cie_pkg::CIE_PH_DATA;
      next_st.wr    = hwrite & word_ok;
      next_st.addr  = word_ok ? haddr[7:0] : 8'hff;
    end else if (hready) begin
      next_st.phase = cie_pkg::CIE_PH_IDLE;
      next_st.wr    = 1'b0;
    end

    // Software writes; unmapped offsets are ignored.
    if (wr_fire) begin
      case (st.addr)
        `CIE_OFS_CONTROL: begin
          next_st.control[7:1] = wbyte[7:1];
        end
        `CIE_OFS_PERIPH_EN: begin
          next_st.periph_en = wbyte;
        end
        `CIE_OFS_EDGE_SELECT: begin
          next_st.edge_select = wbyte[0];
        end
        default: begin
          next_st.edge_select = next_st.edge_select;
        end
      endcase
    end

    // The core taking an interrupt masks further requests until
    // software sets the global enable again; this beats a write in
    // the same cycle so the handler is never re-entered.
    if (irq_taken) begin
      next_st.control[`CIE_BIT_GIE] = 1'b0;
    end

    // Hardware sets win over a software clear in the same cycle.
    if (timer0_ovf_pulse) begin
      next_st.control[`CIE_BIT_T0F] = 1'b1;
    end
    if (ext_edge) begin
      next_st.control[`CIE_BIT_EXTF] = 1'b1;
    end
    next_st.control[`CIE_BIT_PCF] = pin_change_any;

    // The request is registered; a flag left pending while the global
    // enable was clear raises it as soon as the enable returns.
    next_st.irq    = request_now & ~irq_taken;
    next_st.vector = `CIE_IRQ_VECTOR;

    // Read data follows the updated state so a read right after a
    // write sees the new value.
    next_st.rdata = 32'h0000_0000;
    if (addr_take & ~hwrite & word_ok) begin
      case (haddr[7:0])
        `CIE_OFS_CONTROL: begin
          next_st.rdata[7:0] = next_st.control;
        end
        `CIE_OFS_PERIPH_EN: begin
          next_st.rdata[7:0] = next_st.periph_en;
        end
        `CIE_OFS_EDGE_SELECT: begin
          next_st.rdata[0] = next_st.edge_select;
        end
        `CIE_OFS_STATUS: begin
          next_st.rdata[`CIE_BIT_ST_REQ]  = st.irq;
          next_st.rdata[`CIE_BIT_ST_PREQ] = periph_pending;
          next_st.rdata[`CIE_BIT_ST_CORE] = core_pending;
        end
        `CIE_OFS_PERIPH_FLAGS: begin
          next_st.rdata[7:0] = periph_flags[7:0];
        end
        `CIE_OFS_PIN_FLAGS: begin
          next_st.rdata[PIN_COUNT-1:0] = per_pin_change_flags;
        end
        default: begin
          next_st.rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  // ============================================================
  // State register
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st           <= '0;
      st.control   <= `CIE_RST_CONTROL;
      st.periph_en <= `CIE_RST_PERIPH_EN;
      st.edge_select <= `CIE_RST_EDGE_SELECT;
      st.vector    <= `CIE_IRQ_VECTOR;
    end else begin
      st <= next_st;
    end
  end

  // ============================================================
  // Outputs
  assign hreadyout   = 1'b1;
  assign hresp       = `CIE_HRESP_OKAY;
  assign hrdata      = st.rdata;
  assign irq_request = st.irq;
  assign irq_vector  = st.vector;

endmodule

// ### testbench/cie_ctrl_assertions.sv
/* Port checker of the interrupt enable and flag block.
   Assumes it is bound to every cie_ctrl instance. */
`timescale 1ns/1ps
`include "cie_cfg.svh"

module cie_ctrl_assertions #(
  parameter int PERIPH_COUNT = 8,
  parameter int PIN_COUNT    = 6
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Register bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // Sources and core
  input wire logic timer0_ovf_pulse,
  input wire logic ext_pin,
  input wire logic [PIN_COUNT-1:0] per_pin_change_flags,
  input wire logic [PERIPH_COUNT-1:0] periph_flags,
  input wire logic irq_taken,
  input wire logic irq_request,
  input wire logic [15:0] irq_vector
);
  // ====================
  // Properties
  wire logic rd_take = hsel && hready && htrans[1] && !hwrite &&
                       hsize == `CIE_HSIZE_WORD;
  wire logic wr_take = hsel && hready && htrans[1] && hwrite;
  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (reset);
  sequence s_rd(logic [7:0] ofs);
    rd_take && haddr[7:0] == ofs;
  endsequence
  sequence s_take_then_rd;
    irq_taken ##1 s_rd(8'h00);
  endsequence
  chk_vector_fixed: assert property (!$past(reset) |->
    irq_vector == `CIE_IRQ_VECTOR) else $error("vector moved");
  chk_req_reset: assert property ($fell(reset) |->
    !irq_request) else $error("request after reset");
  chk_taken_drop: assert property (irq_taken |=>
    !irq_request) else $error("request kept after take");
  chk_taken_clears: assert property (s_take_then_rd |=>
    !hrdata[7]) else $error("global enable kept after take");
  chk_upper_zero: assert property (rd_take |=>
    hrdata[31:8] == 24'h0) else $error("upper read bits set");
  chk_unmapped_zero: assert property (rd_take &&
    haddr[7:0] > 8'h14 |=> hrdata == 32'h0) else $error("unmapped");
  // A write landing between the pulse and the read may clear the flag.
  chk_timer_flag: assert property (timer0_ovf_pulse && !wr_take
    ##1 !wr_take ##1 s_rd(8'h00) |=> hrdata[2])
    else $error("timer flag not set");
  chk_summary_flag: assert property (s_rd(8'h00) |=>
    hrdata[0] == $past(|per_pin_change_flags))
    else $error("summary flag wrong");
  chk_status_req: assert property (s_rd(8'h0c) |=>
    hrdata[0] == $past(irq_request)) else $error("status wrong");
endmodule

bind cie_ctrl cie_ctrl_assertions #(
  .PERIPH_COUNT(PERIPH_COUNT), .PIN_COUNT(PIN_COUNT)
) cie_ctrl_assertions_i (
  .clk_sys(clk_sys), .reset(reset), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .hrdata(hrdata), .timer0_ovf_pulse(timer0_ovf_pulse),
  .ext_pin(ext_pin), .per_pin_change_flags(per_pin_change_flags),
  .periph_flags(periph_flags), .irq_taken(irq_taken),
  .irq_request(irq_request), .irq_vector(irq_vector)
);

// ### testbench/cie_core_model.sv
/* Behavioural processor core that takes the interrupt request.
   Assumes irq_request is a registered level on clk_sys. */
`timescale 1ns/1ps

module cie_core_model (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic reset,
  // Request side
  input  wire logic accept,
  input  wire logic irq_request,
  output logic      irq_taken
);
  // A stalled core (accept low) leaves the request pending.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      irq_taken <= 1'h0;
    end else begin
      irq_taken <= accept && irq_request && !irq_taken;
    end
  end
endmodule

// ### testbench/core_irq_enable_flag_logic_test.sv
/* Self-checking bench of the interrupt enable and flag block.
   Assumes the design, checker and core model are compiled first. */
`timescale 1ns/1ps
`include "cie_cfg.svh"
`define CHK(got, exp) begin \
  total_checks++; \
  if ((got) !== (exp)) begin \
    mismatches++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, got, exp); \
  end \
end

module core_irq_enable_flag_logic_test;
  // ====================
  // Signals
  localparam logic [7:0] ctl = `CIE_OFS_CONTROL;
  localparam logic [7:0] pen = `CIE_OFS_PERIPH_EN;
  logic clk_sys = 1'h0;
  logic reset = 1'h1;
  logic hsel = 1'h0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'h0;
  logic [31:0] hwdata = 32'h0;
  logic t0_pulse = 1'h0;
  logic ext_pin = 1'h0;
  logic [5:0] pins = 6'h0;
  logic [7:0] pflags = 8'h0;
  logic accept = 1'h0;
  logic [7:0] m;
  logic [31:0] rd;
  wire logic hready, hresp, irq_taken, irq_request;
  wire logic [31:0] hrdata;
  wire logic [15:0] irq_vector;
  int mismatches = 0;
  int total_checks = 0;
  int cycles = 0;

  cie_ctrl cie_ctrl_i (
    .clk_sys(clk_sys), .reset(reset), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(`CIE_HSIZE_WORD),
    .hwdata(hwdata), .hready(hready), .hreadyout(hready),
    .hresp(hresp), .hrdata(hrdata), .timer0_ovf_pulse(t0_pulse),
    .ext_pin(ext_pin), .per_pin_change_flags(pins),
    .periph_flags(pflags), .irq_taken(irq_taken),
    .irq_request(irq_request), .irq_vector(irq_vector));
  cie_core_model cie_core_model_i (.clk_sys(clk_sys), .reset(reset),
    .accept(accept), .irq_request(irq_request), .irq_taken(irq_taken));

  // ====================
  // Clock, timeout and tasks
  always #2 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // The bus never stretches here, but the loops keep a slow slave safe.
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    hsel <= 1'h1;
    htrans <= `CIE_HTRANS_NONSEQ;
    hwrite <= wr;
    haddr <= {24'h0, a};
    @(posedge clk_sys);
    while (!hready) @(posedge clk_sys);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk_sys);
    while (!hready) @(posedge clk_sys);
    rd = hrdata;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    bus(1'h0, a, 32'h0);
    `CHK(rd, e)
    `CHK(hresp, `CIE_HRESP_OKAY)
  endtask
  task automatic req_chk(input logic e);
    repeat (3) @(posedge clk_sys);
    `CHK(irq_request, e)
  endtask
  task automatic src(input int s, input logic v);
    case (s)
      0: pins <= {5'h0, v};
      1: ext_pin <= v;
      default: t0_pulse <= v;
    endcase
    @(posedge clk_sys);
    t0_pulse <= 1'h0;
    @(posedge clk_sys);
  endtask

  // ====================
  // Main sequence
  initial begin
    repeat (12) @(posedge clk_sys);
    reset <= 1'h0;
    @(posedge clk_sys);
    rd_chk(ctl, 32'h0);
    rd_chk(pen, 32'h0);
    bus(1'h1, 8'h20, 32'hff);
    rd_chk(8'h20, 32'h0);
    for (int i = 0; i < 8; i++) begin
      m = 8'h1 << i;
      pflags <= m;
      bus(1'h1, pen, {24'h0, ~m});
      bus(1'h1, ctl, 32'hc0);
      req_chk(1'h0);
      bus(1'h1, pen, {24'h0, m});
      rd_chk(pen, {24'h0, m});
      req_chk(1'h1);
      rd_chk(`CIE_OFS_STATUS, 32'h3);
      rd_chk(`CIE_OFS_PERIPH_FLAGS, {24'h0, m});
      bus(1'h1, ctl, 32'h80);
      req_chk(1'h0);
      bus(1'h1, ctl, 32'h40);
      req_chk(1'h0);
    end
    pflags <= 8'h0;
    bus(1'h1, `CIE_OFS_EDGE_SELECT, 32'h1);
    for (int s = 0; s < 3; s++) begin
      src(s, 1'h1);
      bus(1'h1, ctl, 32'h80 | (32'h1 << s));
      rd_chk(ctl, 32'h80 | (32'h1 << s));
      req_chk(1'h0);
      bus(1'h1, ctl, 32'h80 | (32'h9 << s));
      req_chk(1'h1);
      src(s, 1'h0);
      bus(1'h1, ctl, 32'h0);
      rd_chk(ctl, 32'h0);
    end
    pins <= 6'h20;
    repeat (2) @(posedge clk_sys);
    rd_chk(`CIE_OFS_PIN_FLAGS, 32'h20);
    bus(1'h1, ctl, 32'h0);
    rd_chk(ctl, 32'h1);
    bus(1'h1, `CIE_OFS_EDGE_SELECT, 32'h0);
    src(1, 1'h1);
    rd_chk(ctl, 32'h1);
    src(1, 1'h0);
    rd_chk(ctl, 32'h3);
    pins <= 6'h0;
    bus(1'h1, ctl, 32'h20);
    src(2, 1'h1);
    rd_chk(ctl, 32'h24);
    accept <= 1'h1;
    req_chk(1'h0);
    bus(1'h1, ctl, 32'ha4);
    // Read right after the take, so the checker sees the enable drop.
    while (!irq_taken) @(posedge clk_sys);
    rd_chk(ctl, 32'h24);
    `CHK(irq_request, 1'h0)
    `CHK(irq_vector, `CIE_IRQ_VECTOR)
    accept <= 1'h0;
    bus(1'h1, pen, 32'hff);
    reset <= 1'h1;
    repeat (3) @(posedge clk_sys);
    reset <= 1'h0;
    @(posedge clk_sys);
    rd_chk(ctl, 32'h0);
    rd_chk(pen, 32'h0);
    give_verdict();
  end
endmodule
